// ---- sep_params.svh ----
// Purpose: Timing and reset constants for the serial memory pin control block
// Assumes: 50 ns system clock period
// Notes:   Cycle counts derive from the printed times; wide counts are top parameters
`ifndef SEP_PARAMS_SVH
`define SEP_PARAMS_SVH

`define SEP_CLK_PERIOD_NS   50.0
`define SEP_T_PU_MIN_MS     0.1
`define SEP_T_PU_MAX_MS     1
`define SEP_T_WR_MS         5
`define SEP_T_GLITCH_NS     100

`define SEP_PU_CYC          (int'($ceil(`SEP_T_PU_MIN_MS * 1.0E6 / `SEP_CLK_PERIOD_NS)))
`define SEP_PU_MAX_CYC      (int'($floor(`SEP_T_PU_MAX_MS * 1.0E6 / `SEP_CLK_PERIOD_NS)))
`define SEP_WR_CYC          (int'($floor(`SEP_T_WR_MS * 1.0E6 / `SEP_CLK_PERIOD_NS)))
`define SEP_GLITCH_CYC      (int'($ceil(`SEP_T_GLITCH_NS / `SEP_CLK_PERIOD_NS)))

`define SEP_LINE_IDLE       1'h1
`define SEP_BITS_PER_BYTE   4'h8
`define SEP_ADDR_HI_IDX     2'h0
`define SEP_ADDR_LO_IDX     2'h1
`define SEP_FIRST_DATA_IDX  2'h2
`define SEP_TYPE_MSB        7
`define SEP_TYPE_LSB        4
`define SEP_SEL_MSB         3
`define SEP_SEL_LSB         1
`define SEP_RW_BIT          0

`endif

// ---- sep_pkg.sv ----
// Purpose: Types shared by the serial memory pin control block
// Assumes: Nothing
// Notes:   Constants live in sep_params.svh
package sep_pkg;
    typedef enum logic [2:0] {
        SEP_ST_POR,
        SEP_ST_IDLE,
        SEP_ST_ADDR,
        SEP_ST_ACK,
        SEP_ST_RX,
        SEP_ST_TX,
        SEP_ST_TXACK,
        SEP_ST_WRITE
    } sep_state_e;
endpackage

// ---- sep_line_if.sv ----
// Purpose: Filtered bus line level and its edges
// Assumes: All signals on the system clock
// Notes:   Edges are one-cycle pulses
`timescale 1ns/1ps
interface sep_line_if;
    logic lvl;
    logic rise;
    logic fall;
    modport src (output lvl, output rise, output fall);
    modport dst (input lvl, input rise, input fall);
endinterface

// ---- sep_filter.sv ----
// Purpose: Synchronise a bus pin and reject short pulses
// Assumes: Pin idles high
// Notes:   Output moves only after the input differs for FILT_CYC+2 samples
`timescale 1ns/1ps
`include "sep_params.svh"
module sep_filter import sep_pkg::*; #(
    parameter int FILT_CYC = `SEP_GLITCH_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Pin and filtered line
    input wire logic raw,
    sep_line_if.src  line
);
    localparam logic [3:0] LIMIT = 4'(FILT_CYC + 1);

    logic       meta_reg;
    logic       sync_reg;
    logic       lvl_reg;
    logic       rise_reg;
    logic       fall_reg;
    logic [3:0] cnt_reg;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= `SEP_LINE_IDLE;
            sync_reg <= `SEP_LINE_IDLE;
        end else begin
            meta_reg <= raw;
            sync_reg <= meta_reg;
        end
    end

    // A pulse of the reject width spans at most FILT_CYC+1 samples
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            lvl_reg  <= `SEP_LINE_IDLE;
            rise_reg <= 1'h0;
            fall_reg <= 1'h0;
            cnt_reg  <= 4'h0;
        end else begin
            rise_reg <= 1'h0;
            fall_reg <= 1'h0;
            if (sync_reg == lvl_reg) begin
                cnt_reg <= 4'h0;
            end else if (cnt_reg == LIMIT) begin
                lvl_reg  <= sync_reg;
                rise_reg <= sync_reg;
                fall_reg <= ~sync_reg;
                cnt_reg  <= 4'h0;
            end else begin
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end

    assign line.lvl  = lvl_reg;
    assign line.rise = rise_reg;
    assign line.fall = fall_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_glitch_reject;
        $changed(lvl_reg) |-> $past(cnt_reg) == LIMIT;
    endproperty
    a_glitch_reject: assert property (p_glitch_reject)
        else $error("filtered line changed before the reject window elapsed");
endmodule // sep_filter

// ---- sep_top.sv ----
// Purpose: Pin control of a serial memory slave: power-up, select straps, inhibit, bus
// Assumes: sys_rst is the supply-triggered power-on reset; memory array lies outside
// Notes:   Received data bytes go out through a two-entry buffer; a full buffer refuses
`timescale 1ns/1ps
`include "sep_params.svh"
module sep_top import sep_pkg::*; #(
    parameter int         PU_CYC   = `SEP_PU_CYC,
    parameter int         WR_CYC   = `SEP_WR_CYC,
    parameter int         FILT_CYC = `SEP_GLITCH_CYC,
    // Device type prefix; value is arbitrary
    parameter logic [3:0] DEV_TYPE = 4'h5
) (
    // Clock and power-on reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Straps
    input  wire logic       select_bit_0,
    input  wire logic       select_bit_1,
    input  wire logic       select_bit_2,
    input  wire logic       write_inhibit,
    // Memory side
    output logic [15:0]     mem_addr,
    output logic [7:0]      wr_data,
    output logic            wr_valid,
    input  wire logic       wr_ready,
    output logic            wr_commit,
    input  wire logic [7:0] rd_data,
    output logic            rd_take,
    // Status
    output logic            dev_ready,
    output logic            write_busy
);
    localparam int PU_W = $clog2(PU_CYC + 1);
    localparam int WR_W = $clog2(WR_CYC + 1);
    localparam logic [PU_W-1:0] PU_LAST = PU_W'(PU_CYC - 1);
    localparam logic [WR_W-1:0] WR_LAST = WR_W'(WR_CYC - 1);

    sep_line_if scl_l ();
    sep_line_if sda_l ();

    // clock is only an input here
    sep_filter #(.FILT_CYC(FILT_CYC)) u_scl_filt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .raw     (scl_in),
        .line    (scl_l)
    );
    sep_filter #(.FILT_CYC(FILT_CYC)) u_sda_filt (
        .clk     (clk),
        .sys_rst (sys_rst),
        .raw     (sda_in),
        .line    (sda_l)
    );

    sep_state_e      state_reg;
    logic [3:0]      meta_reg;
    logic [3:0]      strap_reg;
    logic [PU_W-1:0] pu_cnt_reg;
    logic [WR_W-1:0] wr_cnt_reg;
    logic [7:0]      shift_reg;
    logic [3:0]      bit_cnt_reg;
    logic [1:0]      byte_idx_reg;
    logic            rw_reg;
    logic            mack_reg;
    logic            wp_lat_reg;
    logic            got_data_reg;
    logic            oe_reg;
    logic            commit_reg;
    logic [15:0]     addr_reg;
    logic [7:0]      fifo_mem [2];
    logic            wptr_reg;
    logic            rptr_reg;
    logic [1:0]      count_reg;

    logic start_ev, stop_ev, byte_done, addr_match, fifo_in_ready, data_ok, push, load_rd;
    logic in_bus;

    // Straps pass two flops; unconnected pins read low by their pull-downs
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg  <= 4'h0;
            strap_reg <= 4'h0;
        end else begin
            meta_reg  <= {write_inhibit, select_bit_2, select_bit_1, select_bit_0};
            strap_reg <= meta_reg;
        end
    end

    // Power-up delay counter
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pu_cnt_reg <= '0;
        end else if (state_reg == SEP_ST_POR && pu_cnt_reg != PU_LAST) begin
            pu_cnt_reg <= pu_cnt_reg + PU_W'(1);
        end
    end

    // Internal write cycle timer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_cnt_reg <= '0;
        end else if (state_reg == SEP_ST_WRITE) begin
            wr_cnt_reg <= wr_cnt_reg + WR_W'(1);
        end else begin
            wr_cnt_reg <= '0;
        end
    end

    assign in_bus        = state_reg != SEP_ST_POR && state_reg != SEP_ST_WRITE;
    assign start_ev      = in_bus && sda_l.fall && scl_l.lvl;
    assign stop_ev       = in_bus && sda_l.rise && scl_l.lvl;
    assign byte_done     = scl_l.fall && bit_cnt_reg == `SEP_BITS_PER_BYTE;
    assign addr_match    = shift_reg[`SEP_TYPE_MSB:`SEP_TYPE_LSB] == DEV_TYPE
                           && shift_reg[`SEP_SEL_MSB:`SEP_SEL_LSB] == strap_reg[2:0];
    assign fifo_in_ready = count_reg != 2'h2;
    assign data_ok       = !wp_lat_reg && fifo_in_ready;
    assign push          = !start_ev && !stop_ev && state_reg == SEP_ST_RX && byte_done
                           && byte_idx_reg >= `SEP_FIRST_DATA_IDX && data_ok;
    assign load_rd       = !start_ev && !stop_ev && scl_l.fall
                           && ((state_reg == SEP_ST_ACK && rw_reg)
                               || (state_reg == SEP_ST_TXACK && mack_reg));

    // Bus sequencer and pin drive
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_reg    <= SEP_ST_POR;
            shift_reg    <= 8'h00;
            bit_cnt_reg  <= 4'h0;
            byte_idx_reg <= 2'h0;
            rw_reg       <= 1'h0;
            mack_reg     <= 1'h0;
            wp_lat_reg   <= 1'h0;
            got_data_reg <= 1'h0;
            oe_reg       <= 1'h0;
            commit_reg   <= 1'h0;
            addr_reg     <= 16'h0000;
        end else begin
            commit_reg <= 1'h0;
            if (state_reg == SEP_ST_POR) begin
                oe_reg <= 1'h0;
                if (pu_cnt_reg == PU_LAST) begin
                    state_reg <= SEP_ST_IDLE;
                end
            end else if (state_reg == SEP_ST_WRITE) begin
                oe_reg <= 1'h0;
                if (wr_cnt_reg == WR_LAST) begin
                    state_reg <= SEP_ST_IDLE;
                end
            end else if (start_ev) begin
                state_reg    <= SEP_ST_ADDR;
                bit_cnt_reg  <= 4'h0;
                byte_idx_reg <= 2'h0;
                oe_reg       <= 1'h0;
            end else if (stop_ev) begin
                oe_reg       <= 1'h0;
                got_data_reg <= 1'h0;
                commit_reg   <= got_data_reg;
                state_reg    <= got_data_reg ? SEP_ST_WRITE : SEP_ST_IDLE;
            end else begin
                unique case (state_reg)
                    SEP_ST_ADDR, SEP_ST_RX: begin
                        if (scl_l.rise) begin
                            shift_reg   <= {shift_reg[6:0], sda_l.lvl};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                        end else if (byte_done) begin
                            if (state_reg == SEP_ST_ADDR) begin
                                rw_reg    <= shift_reg[`SEP_RW_BIT];
                                oe_reg    <= addr_match;
                                state_reg <= addr_match ? SEP_ST_ACK : SEP_ST_IDLE;
                            end else if (byte_idx_reg < `SEP_FIRST_DATA_IDX || data_ok) begin
                                oe_reg    <= 1'h1;
                                state_reg <= SEP_ST_ACK;
                                if (byte_idx_reg == `SEP_ADDR_HI_IDX) begin
                                    addr_reg[15:8] <= shift_reg;
                                end else if (byte_idx_reg == `SEP_ADDR_LO_IDX) begin
                                    addr_reg[7:0] <= shift_reg;
                                end else begin
                                    got_data_reg <= 1'h1;
                                end
                                if (byte_idx_reg != `SEP_FIRST_DATA_IDX) begin
                                    byte_idx_reg <= byte_idx_reg + 2'h1;
                                end
                            end else begin
                                state_reg <= SEP_ST_IDLE;
                            end
                        end
                    end
                    SEP_ST_ACK: begin
                        if (scl_l.fall) begin
                            if (!rw_reg && byte_idx_reg == `SEP_FIRST_DATA_IDX
                                && !got_data_reg) begin
                                wp_lat_reg <= strap_reg[3];
                            end
                            if (rw_reg) begin
                                shift_reg   <= rd_data;
                                oe_reg      <= ~rd_data[7];
                                bit_cnt_reg <= 4'h1;
                                state_reg   <= SEP_ST_TX;
                            end else begin
                                oe_reg      <= 1'h0;
                                bit_cnt_reg <= 4'h0;
                                state_reg   <= SEP_ST_RX;
                            end
                        end
                    end
                    SEP_ST_TX: begin
                        if (scl_l.fall) begin
                            if (bit_cnt_reg == `SEP_BITS_PER_BYTE) begin
                                oe_reg    <= 1'h0;
                                state_reg <= SEP_ST_TXACK;
                            end else begin
                                oe_reg      <= ~shift_reg[6];
                                shift_reg   <= {shift_reg[6:0], 1'h0};
                                bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            end
                        end
                    end
                    SEP_ST_TXACK: begin
                        if (scl_l.rise) begin
                            mack_reg <= ~sda_l.lvl;
                        end else if (load_rd) begin
                            shift_reg   <= rd_data;
                            oe_reg      <= ~rd_data[7];
                            bit_cnt_reg <= 4'h1;
                            state_reg   <= SEP_ST_TX;
                        end else if (scl_l.fall) begin
                            state_reg <= SEP_ST_IDLE;
                        end
                    end
                    SEP_ST_IDLE: begin
                        oe_reg <= 1'h0;
                    end
                    default: begin
                        state_reg <= SEP_ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Two-entry write buffer; a full buffer refuses the byte rather than lose it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wptr_reg    <= 1'h0;
            rptr_reg    <= 1'h0;
            count_reg   <= 2'h0;
            fifo_mem[0] <= 8'h00;
            fifo_mem[1] <= 8'h00;
        end else begin
            if (push) begin
                fifo_mem[wptr_reg] <= shift_reg;
                wptr_reg           <= ~wptr_reg;
            end
            if (wr_valid && wr_ready) begin
                rptr_reg <= ~rptr_reg;
            end
            count_reg <= count_reg + 2'(push) - 2'(wr_valid && wr_ready);
        end
    end

    assign sda_out    = 1'h0;
    assign sda_oe     = oe_reg;
    assign mem_addr   = addr_reg;
    assign wr_data    = fifo_mem[rptr_reg];
    assign wr_valid   = count_reg != 2'h0;
    assign wr_commit  = commit_reg;
    assign rd_take    = load_rd;
    assign dev_ready  = state_reg != SEP_ST_POR;
    assign write_busy = state_reg == SEP_ST_WRITE;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_por_quiet;
        state_reg == SEP_ST_POR |-> !oe_reg && !wr_valid && !rd_take;
    endproperty
    a_por_quiet: assert property (p_por_quiet)
        else $error("bus active during power-on reset");

    property p_ready_time;
        $rose(dev_ready) |-> $past(pu_cnt_reg) == PU_LAST;
    endproperty
    a_ready_time: assert property (p_ready_time)
        else $error("standby entered at wrong power-up count");

    property p_drive_only_ack_tx;
        oe_reg |-> state_reg inside {SEP_ST_ACK, SEP_ST_TX};
    endproperty
    a_drive_only_ack_tx: assert property (p_drive_only_ack_tx)
        else $error("data pin pulled low outside acknowledge or transmit");

    property p_drive_after_fall;
        $rose(oe_reg) |-> $past(scl_l.fall);
    endproperty
    a_drive_after_fall: assert property (p_drive_after_fall)
        else $error("data pin changed without a clock fall");

    property p_addr_ack_match;
        $past(state_reg) == SEP_ST_ADDR && state_reg == SEP_ST_ACK
            |-> $past(shift_reg[3:1]) == $past(strap_reg[2:0]);
    endproperty
    a_addr_ack_match: assert property (p_addr_ack_match)
        else $error("acknowledged an address with wrong select bits");

    property p_inhibit_push;
        push |-> !wp_lat_reg ##1 wr_valid;
    endproperty
    a_inhibit_push: assert property (p_inhibit_push)
        else $error("write byte accepted while inhibited");

    property p_write_silent;
        state_reg == SEP_ST_WRITE |-> !oe_reg && !rd_take && !push;
    endproperty
    a_write_silent: assert property (p_write_silent)
        else $error("bus answered during internal write");

    property p_commit_to_write;
        wr_commit |-> state_reg == SEP_ST_WRITE && $past(stop_ev);
    endproperty
    a_commit_to_write: assert property (p_commit_to_write)
        else $error("write cycle not started by stop");

    property p_ack_release;
        state_reg == SEP_ST_ACK && scl_l.fall && !rw_reg && !start_ev && !stop_ev
            |=> !oe_reg && state_reg == SEP_ST_RX;
    endproperty
    a_ack_release: assert property (p_ack_release)
        else $error("acknowledge not released after ninth clock");
endmodule // sep_top

// ---- sep_master.sv ----
// Purpose: Bus master model that makes the serial clock and drives data
// Assumes: Open-drain wiring is resolved by the bench; clk is the sampling clock
// Notes:   Low phase is stretched where the slave drives data, to cover its filter lag
`timescale 1ns/1ps
module sep_master (
    // Clock
    input wire logic clk,
    // Bus
    input wire logic sda_line,
    output logic     scl_o,
    output logic     sda_o
);
    // Both lines released while no frame runs
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end

    task automatic q(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Only this model and t_glitch move the clock; short low phase gives 400 ns per bit
    task automatic bitx(input logic b, input int lo, output logic r);
        sda_o <= b;
        q(lo);
        scl_o <= 1'h1;
        q(3);
        @(negedge clk) r = sda_line;
        @(posedge clk) scl_o <= 1'h0;
        q(1);
    endtask

    task automatic start();
        sda_o <= 1'h1;
        q(10);
        scl_o <= 1'h1;
        q(4);
        sda_o <= 1'h0;
        q(4);
        scl_o <= 1'h0;
        q(1);
    endtask

    task automatic stop();
        sda_o <= 1'h0;
        q(10);
        scl_o <= 1'h1;
        q(4);
        sda_o <= 1'h1;
        q(10);
    endtask

    // Ninth slot released so the slave can answer
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], (i == 7) ? 9 : 3, r);
        end
        bitx(1'h1, 9, r);
        ack = ~r;
    endtask

    // Master pulls low in the ninth slot to ask for more
    task automatic rbyte(input logic mack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bitx(1'h1, 9, d[i]);
        end
        bitx(~mack, 9, r);
    endtask

    // Two-sample pulse, 100 ns, on one line
    task automatic pulse(input logic on_clk);
        if (on_clk) begin
            scl_o <= ~scl_o;
            q(2);
            scl_o <= ~scl_o;
        end else begin
            sda_o <= ~sda_o;
            q(2);
            sda_o <= ~sda_o;
        end
        q(6);
    endtask
endmodule // sep_master

// ---- sep_top_bench.sv ----
// Purpose: Self-checking bench for the serial memory pin control block
// Assumes: Design timing as handed over; short power-up and write counts
// Notes:   Straps driven low stand in for unconnected pins
`timescale 1ns/1ps
module sep_top_bench;
    localparam int         PU = 200;
    localparam int         WR = 400;
    // Device type prefix; value is arbitrary
    localparam logic [3:0] DT = 4'h5;

    logic        clk, sys_rst, scl, m_sda, sda_out, sda_oe;
    logic        wr_valid, wr_ready, wr_commit, rd_take, dev_ready;
    logic        write_busy, write_inhibit;
    logic [2:0]  sel;
    logic [15:0] mem_addr;
    logic [7:0]  wr_data, rd_data;
    int          bad_count = 0;
    int          compares = 0;
    int          commits = 0;
    int          takes = 0;
    wire         sda_line = m_sda & ~sda_oe;

    sep_master m (.clk(clk), .sda_line(sda_line), .scl_o(scl), .sda_o(m_sda));

    sep_top #(.PU_CYC(PU), .WR_CYC(WR), .FILT_CYC(2), .DEV_TYPE(DT)) DUT (
        .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .select_bit_0(sel[0]),
        .select_bit_1(sel[1]), .select_bit_2(sel[2]), .write_inhibit(write_inhibit),
        .mem_addr(mem_addr), .wr_data(wr_data), .wr_valid(wr_valid),
        .wr_ready(wr_ready), .wr_commit(wr_commit), .rd_data(rd_data),
        .rd_take(rd_take), .dev_ready(dev_ready), .write_busy(write_busy));

    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end

    initial begin
        sys_rst = 1'h1;
        wr_ready = 1'h0;
        write_inhibit = 1'h0;
        sel = 3'h0;
        rd_data = 8'h3C;
    end

    always @(posedge clk) if (wr_commit === 1'h1) commits <= commits + 1;
    always @(posedge clk) if (rd_take === 1'h1) takes <= takes + 1;

    function automatic logic [7:0] adr(input logic [2:0] s, input logic rw);
        return {DT, s, rw};
    endfunction

    task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk_bit(input string n, input logic e, input logic g);
        chk_val(n, {15'h0, e}, {15'h0, g});
    endtask

    task automatic finish_test();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic t_reset();
        int n;
        n = 0;
        @(posedge clk) sys_rst <= 1'h1;
        repeat (4) @(posedge clk);
        chk_bit("ready_in_reset", 1'h0, dev_ready);
        chk_bit("oe_in_reset", 1'h0, sda_oe);
        chk_bit("valid_in_reset", 1'h0, wr_valid);
        sys_rst <= 1'h0;
        // The release edge itself does not count towards the power-up delay
        @(negedge clk);
        // No command before the block reports ready
        while (dev_ready !== 1'h1 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk_val("ready_cycles", 16'(PU), 16'(n));
        $display("test reset done");
    endtask

    task automatic pop();
        @(posedge clk) wr_ready <= 1'h1;
        @(posedge clk) wr_ready <= 1'h0;
        @(negedge clk);
    endtask

    task automatic t_write();
        logic [2:0] a;
        logic       b;
        int         n;
        m.start();
        m.wbyte(adr(3'h0, 1'h0), a[0]);
        m.wbyte(8'h12, a[1]);
        m.wbyte(8'h34, a[2]);
        chk_val("addr_acks", 16'h7, {13'h0, a});
        m.wbyte(8'h5B, a[0]);
        m.wbyte(8'h6C, a[1]);
        m.wbyte(8'h7D, a[2]);
        m.stop();
        chk_val("data_acks", 16'h3, {13'h0, a});
        chk_val("mem_addr", 16'h1234, mem_addr);
        chk_bit("busy", 1'h1, write_busy);
        chk_val("commits", 16'h1, 16'(commits));
        m.start();
        m.wbyte(adr(3'h0, 1'h0), b);
        m.stop();
        chk_bit("ack_busy", 1'h0, b);
        chk_val("head0", 16'h5B, {8'h0, wr_data});
        pop();
        chk_val("head1", 16'h6C, {8'h0, wr_data});
        pop();
        chk_bit("empty", 1'h0, wr_valid);
        n = 0;
        while (write_busy !== 1'h0 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        $display("test write done");
    endtask

    task automatic t_select();
        logic a;
        @(posedge clk) sel <= 3'h5;
        for (int s = 0; s < 8; s++) begin
            m.start();
            m.wbyte(adr(3'(s), 1'h0), a);
            m.stop();
            chk_bit("sel_ack", s == 5, a);
        end
        @(posedge clk) sel <= 3'h0;
        $display("test select done");
    endtask

    task automatic t_inhibit();
        logic a;
        @(posedge clk) write_inhibit <= 1'h1;
        m.start();
        m.wbyte(adr(3'h0, 1'h0), a);
        m.wbyte(8'h00, a);
        m.wbyte(8'h08, a);
        m.wbyte(8'h99, a);
        m.stop();
        chk_bit("ack_inhibit", 1'h0, a);
        chk_bit("valid_inhibit", 1'h0, wr_valid);
        chk_bit("busy_inhibit", 1'h0, write_busy);
        @(posedge clk) write_inhibit <= 1'h0;
        $display("test inhibit done");
    endtask

    task automatic t_read();
        logic       a;
        logic [7:0] d;
        m.start();
        m.wbyte(adr(3'h0, 1'h1), a);
        chk_bit("read_ack", 1'h1, a);
        m.rbyte(1'h1, d);
        chk_val("rd0", 16'h3C, {8'h0, d});
        @(posedge clk) rd_data <= 8'hC3;
        m.rbyte(1'h0, d);
        chk_val("rd1", 16'hC3, {8'h0, d});
        m.stop();
        chk_bit("sda_value", 1'h0, sda_out);
        chk_val("takes", 16'h2, 16'(takes));
        $display("test read done");
    endtask

    task automatic t_glitch();
        logic       a;
        logic       r;
        logic [7:0] v;
        v = adr(3'h0, 1'h0);
        // First address bit clocked by hand; a passed data pulse would restart the byte
        m.start();
        m.q(8);
        m.scl_o <= 1'h1;
        m.q(4);
        m.pulse(1'h0);
        m.scl_o <= 1'h0;
        m.q(1);
        for (int i = 6; i >= 0; i--) begin
            m.bitx(v[i], 3, r);
        end
        m.bitx(1'h1, 9, r);
        a = ~r;
        m.stop();
        chk_bit("ack_sda_glitch", 1'h1, a);
        m.start();
        m.pulse(1'h1);
        m.wbyte(adr(3'h0, 1'h0), a);
        m.stop();
        chk_bit("ack_scl_glitch", 1'h1, a);
        $display("test glitch done");
    endtask

    task automatic t_in_reset();
        logic a;
        @(posedge clk) sys_rst <= 1'h1;
        m.start();
        m.wbyte(adr(3'h0, 1'h0), a);
        m.stop();
        chk_bit("ack_in_reset", 1'h0, a);
        t_reset();
        $display("test in_reset done");
    endtask

    initial begin
        t_reset();
        t_write();
        t_select();
        t_inhibit();
        t_read();
        t_glitch();
        t_in_reset();
        finish_test();
    end

    // Tests take well under 1 ms; a hang is cut at 3 ms
    initial begin
        #3000000;
        bad_count++;
        finish_test();
    end
endmodule // sep_top_bench
